/* rtl/scic_regs.vh */
// register map, field positions and divider taps for the clock and idle control
// included by the design file; plain defines only
`ifndef SCIC_REGS_VH
`define SCIC_REGS_VH
// printed offsets are register indices; byte address = 4 * index
`define SCIC_DIVCTL_IDX 8'h30
`define SCIC_SYSCTL2_IDX 8'h39
`define SCIC_DIVCTL_ADDR 12'h0C0
`define SCIC_SYSCTL2_ADDR 12'h0E4
// divider_control fields
`define SCIC_DIVCTL_FSEL_BIT 5
// system_control_two fields
`define SCIC_SYS2_KEEP_BIT 7
`define SCIC_SYS2_ZERO_BIT 5
`define SCIC_SYS2_IDLE_BIT 4
// reset values
`define SCIC_FSEL_RST 1'b0
`define SCIC_PRE_RST 3'h0
`define SCIC_DIV_RST 21'h000000
`define SCIC_MC_RST 4'h1
// prescaler taps: fc/4 and fc/8
`define SCIC_PRE_TAP4 1
`define SCIC_PRE_TAP8 2
// divider taps for the three source clocks
`define SCIC_TBT_TAP 20
`define SCIC_WDT_TAP 16
`define SCIC_TC_TAP 6
// widths
`define SCIC_DIV_W 21
`define SCIC_WAKE_W 8
`endif

/* rtl/scic_clock_idle.v */
// system clock timing generator, idle standby control and apb register slave
// assumes cpu logic on mclk supplies interrupt latches, enables and master enable
// What this block does
// - prescaler, 21-stage divider, machine cycle counter
// - every reset clears prescaler and dividers
// - source clocks for base, watchdog, counter timers
// - select bit picks fc/4 or fc/8
// - divider bits 4,3 read undefined
// - machine cycle is four one-clock states
// - single clock: cycle equals four fc periods
// - reset starts in normal mode
// - idle stops cpu and watchdog, peripherals run
// - writing idle bit one enters idle
// - enabled interrupt ends idle, back to normal
// - master enable set: service interrupt first
// - master enable clear: resume next instruction
// - idle holds memory, registers, psw, port latches
// - program counter held two instructions ahead
// - clearing keep bit resets device
// - control bits 3-0 read undefined
// - keep bit zero or bit5 one resets
// - reset pin low in idle resets after a two-flop sync
//
// Implementation choice: register access over APB.
`include "scic_regs.vh"
module scic_clock_idle (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // external reset pin, active low, asynchronous
  input wire reset_pin_n,
  // apb slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // interrupt state from the cpu
  input wire [`SCIC_WAKE_W-1:0] interrupt_pending_latch,
  input wire [`SCIC_WAKE_W-1:0] individual_interrupt_enable,
  input wire master_interrupt_enable,
  // timing outputs
  output reg [3:0] machine_state_q,
  output reg tbt_src_clk_q,
  output reg watchdog_timer_src_clk_q,
  output reg tc_src_clk_q,
  // standby outputs
  output reg cpu_run_q,
  output reg hold_state_q,
  output reg wake_service_q,
  output reg wake_resume_q,
  output reg device_reset_q
);

  localparam [1:0] ST_NORMAL = 2'b01;
  localparam [1:0] ST_IDLE = 2'b10;

  function addr_hit;
    input [11:0] a;
    input [11:0] ref_addr;
    begin
      addr_hit = (a == ref_addr);
    end
  endfunction

  reg rst_meta_q;
  reg rst_sync_q;
  reg sc_rst_q;
  reg sc_rst_d;
  wire dev_rst;
  reg [2:0] pre_q;
  reg pre_tap_dly_q;
  wire pre_tap;
  wire div_tick;
  reg [`SCIC_DIV_W-1:0] div_q;
  reg fsel_q;
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  wire wake_req;
  wire setup;
  wire access;
  wire hit_div;
  wire hit_sys;
  reg idle_req;

  // pin crosses two flops before use; the first is read only by the second
  always @(posedge mclk) begin
    if (sys_rst) begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
    end else begin
      rst_meta_q <= reset_pin_n;
      rst_sync_q <= rst_meta_q;
    end
  end

  // any reset source: pin, system, internal clock reset
  assign dev_rst = sys_rst | ~rst_sync_q | sc_rst_q;

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign hit_div = addr_hit(paddr, `SCIC_DIVCTL_ADDR);
  assign hit_sys = addr_hit(paddr, `SCIC_SYSCTL2_ADDR);

  // internal reset pulse on a fatal control write
  always @* begin
    sc_rst_d = 1'b0;
    if (access & pwrite & hit_sys) begin
      if (~pwdata[`SCIC_SYS2_KEEP_BIT] | pwdata[`SCIC_SYS2_ZERO_BIT]) begin
        sc_rst_d = 1'b1;
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst | ~rst_sync_q) begin
      sc_rst_q <= 1'b0;
    end else begin
      sc_rst_q <= sc_rst_d & ~sc_rst_q;
    end
  end

  // prescaler on fc; divider input is its fc/4 or fc/8 stage
  assign pre_tap = fsel_q ? pre_q[`SCIC_PRE_TAP8] : pre_q[`SCIC_PRE_TAP4];
  assign div_tick = pre_tap & ~pre_tap_dly_q;

  always @(posedge mclk) begin
    if (dev_rst) begin
      pre_q <= `SCIC_PRE_RST;
      pre_tap_dly_q <= 1'b0;
      div_q <= `SCIC_DIV_RST;
    end else begin
      pre_q <= pre_q + 3'h1;
      pre_tap_dly_q <= pre_tap;
      if (div_tick) begin
        div_q <= div_q + {{(`SCIC_DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // four one-hot states, one fc period each: cycle lasts 4/fc
  always @(posedge mclk) begin
    if (dev_rst) begin
      machine_state_q <= `SCIC_MC_RST;
    end else begin
      machine_state_q <= {machine_state_q[2:0], machine_state_q[3]};
    end
  end

  // source clocks; watchdog clock frozen while idle
  always @(posedge mclk) begin
    if (dev_rst) begin
      tbt_src_clk_q <= 1'b0;
      watchdog_timer_src_clk_q <= 1'b0;
      tc_src_clk_q <= 1'b0;
    end else begin
      tbt_src_clk_q <= div_q[`SCIC_TBT_TAP];
      tc_src_clk_q <= div_q[`SCIC_TC_TAP];
      if (mode_q == ST_NORMAL) begin
        watchdog_timer_src_clk_q <= div_q[`SCIC_WDT_TAP];
      end
    end
  end

  // wake regardless of master enable
  assign wake_req = |(interrupt_pending_latch & individual_interrupt_enable);

  always @* begin
    idle_req = access & pwrite & hit_sys & pwdata[`SCIC_SYS2_IDLE_BIT] &
               pwdata[`SCIC_SYS2_KEEP_BIT] & ~pwdata[`SCIC_SYS2_ZERO_BIT];
  end

  // a pending wake at entry wins, so idle is never entered on top of it
  always @* begin
    mode_d = mode_q;
    case (mode_q)
      ST_NORMAL: begin
        if (idle_req & ~wake_req) begin
          mode_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wake_req) begin
          mode_d = ST_NORMAL;
        end
      end
      default: begin
        mode_d = ST_NORMAL;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (dev_rst) begin
      mode_q <= ST_NORMAL;
      cpu_run_q <= 1'b1;
      hold_state_q <= 1'b0;
      wake_service_q <= 1'b0;
      wake_resume_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cpu_run_q <= (mode_d == ST_NORMAL);
      hold_state_q <= (mode_d == ST_IDLE);
      wake_service_q <= (mode_q == ST_IDLE) & wake_req & master_interrupt_enable;
      wake_resume_q <= (mode_q == ST_IDLE) & wake_req & ~master_interrupt_enable;
    end
  end

  always @(posedge mclk) begin
    if (dev_rst) begin
      device_reset_q <= 1'b1;
    end else begin
      device_reset_q <= sc_rst_d;
    end
  end

  // select bit; other written bits are expected zero and not stored
  always @(posedge mclk) begin
    if (dev_rst) begin
      fsel_q <= `SCIC_FSEL_RST;
    end else if (access & pwrite & hit_div) begin
      fsel_q <= pwdata[`SCIC_DIVCTL_FSEL_BIT];
    end
  end

  // zero-wait apb: ready raised in the access cycle after setup
  always @(posedge mclk) begin
    if (dev_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~(hit_div | hit_sys);
      prdata <= 32'h00000000;
      if (~pwrite & hit_div) begin
        prdata[`SCIC_DIVCTL_FSEL_BIT] <= fsel_q;
      end
      if (~pwrite & hit_sys) begin
        prdata[`SCIC_SYS2_KEEP_BIT] <= 1'b1;
        prdata[`SCIC_SYS2_IDLE_BIT] <= (mode_q == ST_IDLE);
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // scic_clock_idle

/* verif/scic_clock_idle_monitor.sv */
// concurrent checks on the clock and idle control ports
// sees only the top module's ports; bound from the bench top file
`include "scic_regs.vh"
module scic_clock_idle_monitor (
  // clock, reset, apb
  input wire logic mclk, sys_rst, reset_pin_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // interrupt state
  input wire logic [7:0] interrupt_pending_latch, individual_interrupt_enable,
  input wire logic master_interrupt_enable,
  // timing and standby outputs
  input wire logic tbt_src_clk_q, watchdog_timer_src_clk_q, tc_src_clk_q,
  input wire logic [3:0] machine_state_q,
  input wire logic cpu_run_q, hold_state_q, wake_service_q, wake_resume_q, device_reset_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wake;
  assign wake = |(interrupt_pending_latch & individual_interrupt_enable);
  default clocking cb @(posedge mclk); endclocking
  // pin low resets two edges later, before device_reset_q rises
  default disable iff (sys_rst || !reset_pin_n || device_reset_q);
  a_state_ring: assert property (machine_state_q == 4'h1 |=> machine_state_q == 4'h2 ##1 machine_state_q == 4'h4
    ##1 machine_state_q == 4'h8 ##1 machine_state_q == 4'h1) else $error("machine state ring broken");
  a_ready_once: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready timing wrong");
  a_mode_exclusive: assert property (cpu_run_q == !hold_state_q) else $error("run and hold disagree");
  a_wake_exit: assert property (hold_state_q && wake |=> cpu_run_q) else $error("idle not left on wake");
  a_wake_service: assert property (hold_state_q && wake && master_interrupt_enable |=> wake_service_q)
    else $error("service pulse missing");
  a_wake_resume: assert property (hold_state_q && wake && !master_interrupt_enable |=> wake_resume_q && !wake_service_q)
    else $error("resume pulse missing");
  a_wdt_frozen: assert property (hold_state_q [*3] |-> $stable(watchdog_timer_src_clk_q))
    else $error("watchdog clock moved in idle");
  a_reset_vals: assert property (disable iff (1'b0) device_reset_q && $past(device_reset_q) |-> cpu_run_q
    && !hold_state_q && machine_state_q == 4'h1 && !tc_src_clk_q && !tbt_src_clk_q) else $error("reset values wrong");
  a_sys_reset: assert property (psel && penable && pready && pwrite && paddr == `SCIC_SYSCTL2_ADDR
    && (!pwdata[7] || pwdata[5]) |=> device_reset_q) else $error("internal reset missing");
  a_sys2_fixed: assert property (pready && !pwrite && paddr == `SCIC_SYSCTL2_ADDR |-> prdata[7:5] == 3'h4)
    else $error("control bits 7 to 5 wrong");
  a_map_err: assert property (pready |-> pslverr == (paddr != `SCIC_DIVCTL_ADDR && paddr != `SCIC_SYSCTL2_ADDR))
    else $error("pslverr decode wrong");
  c_service: cover property (wake_service_q);
  c_resume: cover property (wake_resume_q);
  c_int_reset: cover property (disable iff (1'b0) device_reset_q && !sys_rst);
endmodule // scic_clock_idle_monitor

/* verif/system_clock_idle_control_test.sv */
// self-checking bench for the clock and idle control block
// drives apb and interrupt levels itself; the checker is bound below
`include "scic_regs.vh"
module system_clock_idle_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, sys_rst, reset_pin_n, psel, penable, pwrite, master_interrupt_enable, err_q, mie_x;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [7:0] interrupt_pending_latch, individual_interrupt_enable, b;
  wire [31:0] prdata;
  wire [3:0] machine_state_q;
  wire pready, pslverr, tbt_src_clk_q, watchdog_timer_src_clk_q, tc_src_clk_q;
  wire cpu_run_q, hold_state_q, wake_service_q, wake_resume_q, device_reset_q;
  int errors, num_checks, cyc, n, i, seed;
  scic_clock_idle u_scic_clock_idle (.*);
  task tally_and_finish;
    $display("errors %0d num_checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; waits on pready, no fixed latency assumed
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    err_q = pslverr;
    chk("pready", 1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    seed = 32'h99d7;
    {sys_rst, reset_pin_n, psel, penable, pwrite, master_interrupt_enable} = 6'h30;
    {paddr, pwdata, interrupt_pending_latch, individual_interrupt_enable} = '0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(0, `SCIC_SYSCTL2_ADDR, 0);
    chk("sys2 reset", 32'h80, rd & 32'hFFFFFFF0);
    apb(0, `SCIC_DIVCTL_ADDR, 0);
    chk("div reset", 0, rd & 32'hFFFFFFE7);
    apb(1, `SCIC_DIVCTL_ADDR, 32'h20);
    apb(0, `SCIC_DIVCTL_ADDR, 0);
    chk("first stage select", 32'h20, rd & 32'hFFFFFFE7);
    apb(1, 12'h100, 32'h90);
    chk("unmapped err", 1, err_q);
    for (i = 0; i < 6; i++) begin
      b = 8'h01 << ($random(seed) & 7);
      mie_x = i[0];
      apb(1, `SCIC_SYSCTL2_ADDR, 32'h90);
      interrupt_pending_latch <= b;
      individual_interrupt_enable <= ~b;
      repeat (4) @(posedge mclk);
      chk("idle held", 0, cpu_run_q);
      master_interrupt_enable <= mie_x;
      individual_interrupt_enable <= b | 8'($random(seed));
      n = 0;
      do @(posedge mclk); while (wake_service_q !== 1'b1 && wake_resume_q !== 1'b1 && ++n < 8);
      chk("service", mie_x, wake_service_q);
      chk("resume", !mie_x, wake_resume_q);
      chk("run after wake", 1, cpu_run_q);
      interrupt_pending_latch <= 8'h00;
    end
    // both internal reset triggers must also clear the select bit
    for (i = 0; i < 2; i++) begin
      apb(1, `SCIC_DIVCTL_ADDR, 32'h20);
      apb(1, `SCIC_SYSCTL2_ADDR, i ? 32'hA0 : 32'h00);
      repeat (4) @(posedge mclk);
      apb(0, `SCIC_DIVCTL_ADDR, 0);
      chk("select after sys reset", 0, rd[5]);
    end
    apb(1, `SCIC_SYSCTL2_ADDR, 32'h90);
    // peripherals keep their clock in idle; tc tap toggles every 256 clocks
    n = 0;
    b = {7'h00, tc_src_clk_q};
    repeat (300) begin
      @(posedge mclk);
      if (tc_src_clk_q !== b[0]) n++;
      b[0] = tc_src_clk_q;
    end
    chk("tc clock in idle", 1, n > 0);
    chk("cpu still idle", 0, cpu_run_q);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("pin reset in idle", 1, device_reset_q & cpu_run_q);
    reset_pin_n <= 1'b1;
    repeat (6) @(posedge mclk);
    apb(0, `SCIC_SYSCTL2_ADDR, 0);
    chk("normal after pin", 32'h80, rd & 32'hF0);
    tally_and_finish;
  end
endmodule // system_clock_idle_control_test
bind scic_clock_idle scic_clock_idle_monitor u_scic_clock_idle_monitor (.*);
